// File: rtl/gdfs_map.svh
// Purpose: Offsets, field positions and reset values of the gate fault status word.
// Assumes: Byte addressing on an 8-bit register port with 32-bit data.
// Notes:   Definitions only; included by its bare name.
`ifndef GDFS_MAP_SVH
`define GDFS_MAP_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define GDFS_ADDR_W       8
`define GDFS_DATA_W       32
`define GDFS_STATUS_OFS   8'hE0
`define GDFS_STATUS_RST   32'h0000_0000
`define GDFS_RSVD_MASK    32'h2100_87FF

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GDFS_B_SUMMARY    31
`define GDFS_B_BUCK       30
`define GDFS_B_ANY_OC     28
`define GDFS_B_POR_CLR    27
`define GDFS_B_OVERVOLT   26
`define GDFS_B_THERM_ANY  25
`define GDFS_B_THERM_WARN 23
`define GDFS_B_THERM_SHUT 22
`define GDFS_B_PH_HI      21
`define GDFS_B_PH_LO      16
`define GDFS_B_OTP        14
`define GDFS_B_BUCK_OC    13
`define GDFS_B_BUCK_LOW   12
`define GDFS_B_CP_UV      11

// ----------------------------------------------------------------------
// Synchroniser
// ----------------------------------------------------------------------
`define GDFS_SYNC_STAGES  2

`endif

// File: rtl/gdfs_pkg.sv
// Purpose: Types shared by the gate fault status block.
// Assumes: Nothing beyond the map header.
// Notes:   Holds types only; numbers live in the map header.
`default_nettype none

package gdfs_pkg;

    // Detector levels, all active high (supply reset raw as detected).
    typedef struct packed {
        logic       buck_fault;
        logic       any_overcurrent;
        logic       supply_por_detect;
        logic       supply_overvoltage;
        logic       thermal_warning_flag;
        logic       thermal_shutdown;
        logic [5:0] phase_overcurrent;   // C hi, C lo, B hi, B lo, A hi, A lo.
        logic       otp_error;
        logic       buck_overcurrent;
        logic       buck_undervoltage;
        logic       charge_pump_low;
    } fault_flags_t;

    // Whole state of the top module.
    typedef struct packed {
        logic [31:0] status_word;        // Registered status word.
        logic [31:0] rdata;              // Read data, valid the cycle after a read.
        logic        driver_fault;       // Registered copy of the summary bit.
    } status_state_t;

endpackage : gdfs_pkg

`default_nettype wire

// File: rtl/fault_flags_if.sv
// Purpose: Carries synchronised fault flags between the block's modules.
// Assumes: Single clock domain.
// Notes:   No clocking block; plain carrier.
`default_nettype none

interface fault_flags_if;
    gdfs_pkg::fault_flags_t flags;       // Synchronised detector levels.
    modport sender   (output flags);
    modport receiver (input  flags);
endinterface : fault_flags_if

`default_nettype wire

// File: rtl/fault_sync.sv
// Purpose: Two-flop synchroniser for the detector inputs.
// Assumes: Synchronous active-high reset.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module fault_sync (
    input  wire logic                   clk_sys,
    input  wire logic                   sys_rst,
    input  wire gdfs_pkg::fault_flags_t raw,
    fault_flags_if.sender               sync_out
);

    gdfs_pkg::fault_flags_t meta;        // First stage, read only by the second.
    gdfs_pkg::fault_flags_t stable;      // Second stage, safe for logic.

    // Both stages clear on reset, then follow the pins.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta   <= '0;
            stable <= '0;
        end else begin
            meta   <= raw;
            stable <= meta;
        end
    end

    assign sync_out.flags = stable;

endmodule : fault_sync

`default_nettype wire

// File: rtl/fault_word_pack.sv
// Purpose: Packs synchronised flags into the 32-bit status word.
// Assumes: Flags are already in the clock domain.
// Notes:   Purely combinational; reserved bits stay zero.
`include "gdfs_map.svh"
`default_nettype none

module fault_word_pack (
    fault_flags_if.receiver   flags_in,
    output logic [31:0]       word
);

    // Builds the word from the detector levels.
    function automatic logic [31:0] build_word(input gdfs_pkg::fault_flags_t f);
        logic [31:0] w;
        logic        thermal_any_flag;
        logic        summary;
        w       = `GDFS_STATUS_RST;
        thermal_any_flag = f.thermal_warning_flag | f.thermal_shutdown;
        summary = f.buck_fault | f.any_overcurrent | f.supply_por_detect
                | f.supply_overvoltage | thermal_any_flag | (|f.phase_overcurrent)
                | f.otp_error | f.buck_overcurrent | f.buck_undervoltage
                | f.charge_pump_low;
        w[`GDFS_B_SUMMARY]                  = summary;
        w[`GDFS_B_BUCK]                     = f.buck_fault;
        w[`GDFS_B_ANY_OC]                   = f.any_overcurrent;
        w[`GDFS_B_POR_CLR]                  = ~f.supply_por_detect;
        w[`GDFS_B_OVERVOLT]                 = f.supply_overvoltage;
        w[`GDFS_B_THERM_ANY]                = thermal_any_flag;
        w[`GDFS_B_THERM_WARN]               = f.thermal_warning_flag;
        w[`GDFS_B_THERM_SHUT]               = f.thermal_shutdown;
        w[`GDFS_B_PH_HI:`GDFS_B_PH_LO]      = f.phase_overcurrent;
        w[`GDFS_B_OTP]                      = f.otp_error;
        w[`GDFS_B_BUCK_OC]                  = f.buck_overcurrent;
        w[`GDFS_B_BUCK_LOW]                 = f.buck_undervoltage;
        w[`GDFS_B_CP_UV]                    = f.charge_pump_low;
        build_word = w & ~`GDFS_RSVD_MASK;
    endfunction

    assign word = build_word(flags_in.flags);

endmodule : fault_word_pack

`default_nettype wire

// File: rtl/gate_fault_status.sv
// Purpose: Read-only gate driver fault status word on a plain register port.
// Assumes: Detector inputs are asynchronous levels; one 50 MHz clock.
// Notes:   Read data appear the cycle after the read strobe, only then.
`include "gdfs_map.svh"
`default_nettype none

module gate_fault_status (
    // ------------------------------------------------------------------
    // Clock and reset.
    // ------------------------------------------------------------------
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,

    // ------------------------------------------------------------------
    // Register port.
    // ------------------------------------------------------------------
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,

    // ------------------------------------------------------------------
    // Fault detector levels, active high, asynchronous.
    // ------------------------------------------------------------------
    input  wire logic        buck_fault,
    input  wire logic        any_overcurrent,
    input  wire logic        supply_por_detect,
    input  wire logic        supply_overvoltage,
    input  wire logic        thermal_warning_flag,
    input  wire logic        thermal_shutdown,
    input  wire logic        phase_c_high_overcurrent,
    input  wire logic        phase_c_low_overcurrent,
    input  wire logic        phase_b_high_overcurrent,
    input  wire logic        phase_b_low_overcurrent,
    input  wire logic        phase_a_high_overcurrent,
    input  wire logic        phase_a_low_overcurrent,
    input  wire logic        otp_error,
    input  wire logic        buck_overcurrent,
    input  wire logic        buck_undervoltage,
    input  wire logic        charge_pump_low,

    // ------------------------------------------------------------------
    // Registered summary for use outside the register port.
    // ------------------------------------------------------------------
    output logic             driver_fault
);

    // ------------------------------------------------------------------
    // Detector gathering
    // ------------------------------------------------------------------

    // Raw detector levels gathered into one record.
    gdfs_pkg::fault_flags_t raw_flags;

    // Packed word computed from the synchronised flags.
    logic [31:0]            packed_word;

    // Write data are never stored; this keeps the port visibly consumed.
    logic                   write_seen;

    // The six switch flags go in the documented order, phase C first.
    always_comb begin
        raw_flags                      = '0;
        raw_flags.buck_fault           = buck_fault;
        raw_flags.any_overcurrent      = any_overcurrent;
        raw_flags.supply_por_detect    = supply_por_detect;
        raw_flags.supply_overvoltage   = supply_overvoltage;
        raw_flags.thermal_warning_flag = thermal_warning_flag;
        raw_flags.thermal_shutdown     = thermal_shutdown;
        raw_flags.phase_overcurrent    = {phase_c_high_overcurrent,
                                          phase_c_low_overcurrent,
                                          phase_b_high_overcurrent,
                                          phase_b_low_overcurrent,
                                          phase_a_high_overcurrent,
                                          phase_a_low_overcurrent};
        raw_flags.otp_error            = otp_error;
        raw_flags.buck_overcurrent     = buck_overcurrent;
        raw_flags.buck_undervoltage    = buck_undervoltage;
        raw_flags.charge_pump_low      = charge_pump_low;
    end

    // ------------------------------------------------------------------
    // Synchronisation and packing
    // ------------------------------------------------------------------

    // Carrier between the synchroniser and the packer.
    fault_flags_if flags_bus ();

    // Two flops per detector before any logic looks at it.
    fault_sync u_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .raw      (raw_flags),
        .sync_out (flags_bus.sender)
    );

    // Places each flag at its bit and forms the summary.
    fault_word_pack u_pack (
        .flags_in (flags_bus.receiver),
        .word     (packed_word)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // True when the address selects the status word.
    function automatic logic hits_status(input logic [7:0] addr);
        hits_status = (addr == `GDFS_STATUS_OFS);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------

    // Current and next state of the whole module.
    gdfs_pkg::status_state_t state;
    gdfs_pkg::status_state_t next_state;

    // Next-state logic: status sampled each clock, reads answered next cycle.
    always_comb begin
        next_state = state;

        next_state.status_word  = packed_word;

        // Summary bit held beside the word so both change together.
        next_state.driver_fault = packed_word[`GDFS_B_SUMMARY];

        // Read data stand for exactly one cycle after a read.
        if (reg_rd) begin
            // A hit returns the word; any other address reads zero.
            if (hits_status(reg_addr)) begin
                next_state.rdata = state.status_word;
            end else begin
                next_state.rdata = 32'h0000_0000;
            end
        end else begin
            // Outside the answer cycle the bus is held at zero.
            next_state.rdata = 32'h0000_0000;
        end
    end

    assign write_seen = reg_wr & hits_status(reg_addr) & (|reg_wdata);

    // Registers every part of the state on each edge.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state.status_word  <= `GDFS_STATUS_RST;
            state.rdata        <= 32'h0000_0000;
            state.driver_fault <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Both outputs come straight from flops.
    assign reg_rdata    = state.rdata;
    assign driver_fault = state.driver_fault;

endmodule : gate_fault_status

`default_nettype wire

// File: bench/gate_fault_status_assertions.sv
// Purpose: Concurrent checks on the ports of the gate fault status block.
// Assumes: One clock, synchronous active-high reset, read data one cycle after the strobe.
// Notes:   Bound to the top module below; sees its ports only.
`default_nettype none

module gate_fault_status_checker (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        buck_fault,
    input wire logic        any_overcurrent,
    input wire logic        supply_por_detect,
    input wire logic        supply_overvoltage,
    input wire logic        thermal_warning_flag,
    input wire logic        thermal_shutdown,
    input wire logic        phase_c_high_overcurrent,
    input wire logic        phase_c_low_overcurrent,
    input wire logic        phase_b_high_overcurrent,
    input wire logic        phase_b_low_overcurrent,
    input wire logic        phase_a_high_overcurrent,
    input wire logic        phase_a_low_overcurrent,
    input wire logic        otp_error,
    input wire logic        buck_overcurrent,
    input wire logic        buck_undervoltage,
    input wire logic        charge_pump_low,
    input wire logic        driver_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [15:0] pins;    // Detector inputs gathered in one vector.
    logic [15:0] pins_q;  // Detector inputs one cycle ago.
    logic [2:0]  calm;    // Cycles the detector inputs have held still.
    logic        rd_q;    // A read of the status word is answered now.
    logic        any_pin; // Some detector reports a fault.
    assign pins = {buck_fault, any_overcurrent, supply_por_detect, supply_overvoltage,
                   thermal_warning_flag, thermal_shutdown, phase_c_high_overcurrent,
                   phase_c_low_overcurrent, phase_b_high_overcurrent,
                   phase_b_low_overcurrent, phase_a_high_overcurrent,
                   phase_a_low_overcurrent, otp_error, buck_overcurrent,
                   buck_undervoltage, charge_pump_low};
    assign any_pin = |pins;
    // Tracks read timing and input quiet time, so that value checks wait out the sync.
    always_ff @(posedge clk_sys) begin
        pins_q <= pins;
        rd_q <= reg_rd && (reg_addr == 8'hE0) && !sys_rst;
        if (sys_rst || (pins != pins_q)) begin
            calm <= 3'h0;
        end else if (calm != 3'h7) begin
            calm <= calm + 3'h1;
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_RDATA_IDLE: assert property (!rd_q |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a status read");
    AST_RSVD_ZERO: assert property ((reg_rdata & 32'h2100_87FF) == 32'h0000_0000)
        else $error("reserved bit set in read data");
    AST_SUMMARY: assert property (rd_q |-> reg_rdata[31] == $past(driver_fault))
        else $error("summary bit differs from driver fault");
    AST_THERMAL: assert property (
        rd_q |-> reg_rdata[25] == (reg_rdata[23] | reg_rdata[22]))
        else $error("thermal summary bit wrong");
    AST_FLAGS: assert property (
        rd_q && calm == 3'h7 && pins == pins_q |->
        {reg_rdata[30], reg_rdata[28], reg_rdata[26], reg_rdata[23:22], reg_rdata[14:11]}
        == {pins[15:14], pins[12:10], pins[3:0]})
        else $error("flag bit differs from detector");
    AST_PHASE: assert property (rd_q && calm == 3'h7 && pins == pins_q |->
        reg_rdata[21:16] == pins[9:4])
        else $error("switch overcurrent bits wrong");
    AST_POR: assert property (rd_q && calm == 3'h7 && pins == pins_q |->
        reg_rdata[27] == !supply_por_detect)
        else $error("supply reset bit not inverted");
    AST_LAT_SET: assert property (any_pin [*5] |-> driver_fault)
        else $error("driver fault late or missing");
    AST_LAT_CLR: assert property (!any_pin [*5] |-> !driver_fault)
        else $error("driver fault without any detector");
endmodule // gate_fault_status_checker

bind gate_fault_status gate_fault_status_checker chk (.clk_sys, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .buck_fault, .any_overcurrent,
    .supply_por_detect, .supply_overvoltage, .thermal_warning_flag, .thermal_shutdown,
    .phase_c_high_overcurrent, .phase_c_low_overcurrent, .phase_b_high_overcurrent,
    .phase_b_low_overcurrent, .phase_a_high_overcurrent, .phase_a_low_overcurrent,
    .otp_error, .buck_overcurrent, .buck_undervoltage, .charge_pump_low, .driver_fault);

`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench for the gate fault status word.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Detector inputs are driven as one vector, ordered as the word's flags.
`default_nettype none
`define CHECK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys   = 1'b0;         // System clock.
    logic        sys_rst   = 1'b1;         // Synchronous reset.
    logic [7:0]  reg_addr  = 8'h00;        // Register address.
    logic [31:0] reg_wdata = 32'h0000_0000; // Write data.
    logic        reg_wr    = 1'b0;         // Write strobe.
    logic        reg_rd    = 1'b0;         // Read strobe.
    logic [15:0] pins      = 16'h0000;     // Detector levels, buck fault first.
    logic [31:0] reg_rdata;                // Read data.
    logic        driver_fault;             // Registered summary.
    logic [31:0] got;                      // Last read result.
    int          miscompares = 0;          // Mismatches seen.
    int          compares = 0;             // Comparisons made.
    int          cycles = 0;               // Clock cycles run.

    gate_fault_status uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .buck_fault(pins[15]), .any_overcurrent(pins[14]), .supply_por_detect(pins[13]),
        .supply_overvoltage(pins[12]), .thermal_warning_flag(pins[11]),
        .thermal_shutdown(pins[10]), .phase_c_high_overcurrent(pins[9]),
        .phase_c_low_overcurrent(pins[8]), .phase_b_high_overcurrent(pins[7]),
        .phase_b_low_overcurrent(pins[6]), .phase_a_high_overcurrent(pins[5]),
        .phase_a_low_overcurrent(pins[4]), .otp_error(pins[3]), .buck_overcurrent(pins[2]),
        .buck_undervoltage(pins[1]), .charge_pump_low(pins[0]), .driver_fault(driver_fault));

    // Clock of 20 ns period.
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    // Cuts a hang short well past the expected run length.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    // Expected status word for a set of detector levels.
    function automatic logic [31:0] exp_word(input logic [15:0] v);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[31] = |v;
        w[30] = v[15];
        w[28] = v[14];
        w[27] = ~v[13];
        w[26] = v[12];
        w[25] = v[11] | v[10];
        w[23:16] = v[11:4];
        w[14:11] = v[3:0];
        return w;
    endfunction

    // Prints the verdict and stops.
    task automatic conclude();
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One-cycle read or write; read data captured in the answer cycle.
    task automatic access(input logic wr, input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= ~wr;
        reg_wr <= wr;
        reg_addr <= a;
        reg_wdata <= 32'hFFFF_FFFF;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        #1 got = reg_rdata;
    endtask

    // Drives detector levels and lets them pass the synchroniser.
    task automatic settle(input logic [15:0] v);
        @(posedge clk_sys);
        pins <= v;
        repeat (6) @(posedge clk_sys);
    endtask

    // Releases reset and reads at once; the word holds its reset value.
    task automatic t_reset();
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= 8'hE0;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 `CHECK(reg_rdata, 32'h0000_0000)
        `CHECK(driver_fault, 1'b0)
    endtask

    // Walks every detector alone, then none and all.
    task automatic t_map();
        logic [15:0] v;
        logic [31:0] e;
        for (int i = 0; i < 18; i++) begin
            v = (i < 16) ? (16'h0001 << i) : ((i == 16) ? 16'h0000 : 16'hFFFF);
            e = exp_word(v);
            settle(v);
            access(1'b0, 8'hE0);
            `CHECK(got[31:24], e[31:24])
            `CHECK(got[23:16], e[23:16])
            `CHECK(got[15:0], e[15:0])
            `CHECK(driver_fault, |v)
        end
    endtask

    // Writes change nothing, even when a read follows at once; other addresses read zero.
    task automatic t_write();
        settle(16'h0000);
        access(1'b1, 8'hE0);
        `CHECK(got, 32'h0000_0000)
        access(1'b0, 8'hE0);
        `CHECK(got, 32'h0800_0000)
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= 8'hE0;
        reg_wdata <= 32'hFFFF_FFFF;
        // The write is taken here; two reads follow with no gap.
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        #1 `CHECK(reg_rdata, 32'h0800_0000)
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 `CHECK(reg_rdata, 32'h0800_0000)
        settle(16'hFFFF);
        access(1'b0, 8'hE2);
        `CHECK(got, 32'h0000_0000)
    endtask

    // A mid-run reset clears the summary and flushes the synchroniser.
    task automatic t_rerun();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 `CHECK(driver_fault, 1'b0)
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 `CHECK(driver_fault, 1'b0)
        @(posedge clk_sys);
        #1 `CHECK(driver_fault, 1'b1)
    endtask

    // A detector edge reaches the summary after exactly three edges.
    task automatic t_latency();
        settle(16'h0000);
        @(posedge clk_sys);
        pins <= 16'h8000;
        repeat (2) @(posedge clk_sys);
        #1 `CHECK(driver_fault, 1'b0)
        @(posedge clk_sys);
        #1 `CHECK(driver_fault, 1'b1)
    endtask

    // Main sequence.
    initial begin
        t_reset();
        t_map();
        t_write();
        t_latency();
        t_rerun();
        conclude();
    end
endmodule // tb

`default_nettype wire
